/* src/lcd_frame_data_and_status.sv */
// Frame base pointer, pixel unpack and palette, enable sequencing and status flags
`timescale 1ns/1ps
`default_nettype none
`include "lcd_frame_data_defines.svh"
module lcd_frame_data_and_status #(
	parameter int BUF_DEPTH = `LCD_BUF_DEPTH
) (
	input wire logic clk, // 25 MHz block clock
	input wire logic rstn, // Asynchronous active-low reset
	input wire logic controllerEnable, // Controller enable
	input wire logic panelPowerEnable, // Panel power enable
	input wire logic monoSelect, // 1 mono, 0 colour
	input wire logic [1:0] bitsPerPixel, // 0:1 1:2 2:4 3:8 bpp
	input wire logic pixelOrderSelect, // 0 first pixel in MSBs
	input wire logic [31:0] frameBaseAddress, // Frame buffer base
	input wire logic [31:0] redPalette, // Red palette, mono low palette
	input wire logic [31:0] greenPalette, // Green palette, mono high palette
	input wire logic [15:0] bluePalette, // Blue palette
	input wire logic [3:0] displayStatusMask, // Interrupt mask
	input wire logic [3:0] statusClear, // Write-one-to-clear pulses
	input wire logic fetchValid, // Frame byte available
	input wire logic [7:0] fetchByte, // Frame byte, little endian order
	output logic fetchReady, // Byte accepted
	input wire logic panelClk, // Panel pixel clock pin
	input wire logic frameStart, // Frame start level from timing
	input wire logic frameEnd, // Frame end level from timing
	output logic [31:0] currentAddress, // Current frame pointer
	output logic [11:0] panelPixel, // Translated pixel R,G,B
	output logic pixelStrobe, // One-cycle pulse per new pixel
	output logic panelPowerOn, // Panel power control
	output logic running, // Controller active
	output logic [3:0] displayStatus, // Sticky status flags
	output logic [3:0] displayInterruptFlags, // Status AND mask
	output logic interrupt // OR of interrupt flags
);
	// ============================================================
	// Reset release and pin synchronisers
	logic rstMeta, rstSync;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	logic [2:0] pinMeta, pinSync, pinLast;
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			pinMeta <= 3'h0;
			pinSync <= 3'h0;
			pinLast <= 3'h0;
		end else begin
			pinMeta <= {frameEnd, frameStart, panelClk};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end
	logic clkEdge, startEv, endEv;
	assign clkEdge = pinSync[0] && !pinLast[0];
	assign startEv = pinSync[1] && !pinLast[1];
	assign endEv = pinSync[2] && !pinLast[2];

	// ============================================================
	// Run control, base pointer and status flags
	lcd_frame_pkg::status_t next_displayStatus, events;
	logic next_running, underrun;
	logic [31:0] next_currentAddress;

	always_comb begin
		events = `LCD_ST_RESET;
		next_running = running;
		next_currentAddress = currentAddress;
		if (startEv && (controllerEnable || running)) begin
			next_running = 1'b1;
			// Top bit forced low, low bits kept as written
			next_currentAddress = {1'b0, frameBaseAddress[30:0]};
			events[`LCD_ST_NEXT_BASE] = 1'b1;
		end
		if (endEv && running) begin
			events[`LCD_ST_DMA_DONE] = 1'b1;
			if (!controllerEnable) begin
				next_running = 1'b0;
				events[`LCD_ST_STOPPED] = 1'b1;
			end
		end
		events[`LCD_ST_UNDERRUN] = underrun;
		// Hardware set wins over a simultaneous clear
		next_displayStatus = (displayStatus & ~statusClear) | events;
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			running <= 1'b0;
			currentAddress <= `LCD_ADDR_RESET;
			displayStatus <= `LCD_ST_RESET;
			panelPowerOn <= 1'b0;
		end else begin
			running <= next_running;
			currentAddress <= next_currentAddress;
			displayStatus <= next_displayStatus;
			panelPowerOn <= controllerEnable && panelPowerEnable;
		end
	end

	assign displayInterruptFlags = displayStatus & displayStatusMask;
	assign interrupt = |displayInterruptFlags;

	// ============================================================
	// Pixel selection and palette translation
	function automatic logic [7:0] pickPixel(input logic [7:0] b, input logic [1:0] bpp,
		input logic [2:0] idx, input logic order);
		logic [2:0] s1;
		logic [1:0] s2;
		logic s4;
		s1 = order ? idx : 3'h7 - idx;
		s2 = order ? idx[1:0] : 2'h3 - idx[1:0];
		s4 = order ? idx[0] : ~idx[0];
		unique case (bpp)
			`LCD_BPP_1: pickPixel = {7'h00, b[s1]};
			`LCD_BPP_2: pickPixel = {6'h00, b[{s2, 1'b0} +: 2]};
			`LCD_BPP_4: pickPixel = {4'h0, b[{s4, 2'h0} +: 4]};
			`LCD_BPP_8: pickPixel = b;
		endcase
	endfunction : pickPixel

	function automatic lcd_frame_pkg::pixel_t translate(input logic [7:0] v, input logic [1:0] bpp,
		input logic mono, input logic [31:0] redP, input logic [31:0] greenP, input logic [15:0] blueP);
		logic [3:0] r, g, bl;
		if (mono) begin
			// Values 0-7 from low palette, 8-15 from high
			// Mono 1/2 bpp values never exceed 3; blue is never read
			g = v[3] ? greenP[{v[2:0], 2'h0} +: 4] : redP[{v[2:0], 2'h0} +: 4];
			translate = {g, g, g};
		end else if (bpp == `LCD_BPP_8) begin
			r = redP[{v[7:5], 2'h0} +: 4];
			g = greenP[{v[4:2], 2'h0} +: 4];
			bl = blueP[{v[1:0], 2'h0} +: 4];
			translate = {r, g, bl};
		end else begin
			r = redP[{v[2:0], 2'h0} +: 4];
			g = greenP[{v[2:0], 2'h0} +: 4];
			bl = blueP[{v[1:0], 2'h0} +: 4];
			translate = {r, g, bl};
		end
	endfunction : translate

	// ============================================================
	// Byte unpacker feeding the pixel buffer
	lcd_stream_if #(.WIDTH(`LCD_PIXEL_WIDTH)) toBuf ();
	lcd_stream_if #(.WIDTH(`LCD_PIXEL_WIDTH)) fromBuf ();

	lcd_frame_pkg::unpack_state_e state, next_state;
	logic [7:0] heldByte, next_heldByte, curPixel;
	logic [2:0] pixIdx, next_pixIdx, lastIdx;

	always_comb begin
		unique case (bitsPerPixel)
			`LCD_BPP_1: lastIdx = 3'h7;
			`LCD_BPP_2: lastIdx = 3'h3;
			`LCD_BPP_4: lastIdx = 3'h1;
			`LCD_BPP_8: lastIdx = 3'h0;
		endcase
	end

	assign fetchReady = running && (state == lcd_frame_pkg::UNPACK_EMPTY);
	assign toBuf.valid = (state == lcd_frame_pkg::UNPACK_HOLD);
	assign curPixel = pickPixel(heldByte, bitsPerPixel, pixIdx, pixelOrderSelect);
	assign toBuf.data = translate(curPixel, bitsPerPixel, monoSelect, redPalette, greenPalette, bluePalette);

	always_comb begin
		next_state = state;
		next_heldByte = heldByte;
		next_pixIdx = pixIdx;
		unique case (state)
			lcd_frame_pkg::UNPACK_EMPTY: begin
				if (fetchValid && fetchReady) begin
					next_heldByte = fetchByte;
					next_pixIdx = 3'h0;
					next_state = lcd_frame_pkg::UNPACK_HOLD;
				end
			end
			lcd_frame_pkg::UNPACK_HOLD: begin
				if (toBuf.ready) begin
					next_pixIdx = pixIdx + 3'h1;
					if (pixIdx >= lastIdx) begin
						next_state = lcd_frame_pkg::UNPACK_EMPTY;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			state <= lcd_frame_pkg::UNPACK_EMPTY;
			heldByte <= 8'h00;
			pixIdx <= 3'h0;
		end else begin
			state <= next_state;
			heldByte <= next_heldByte;
			pixIdx <= next_pixIdx;
		end
	end

	lcd_pixel_buffer #(.WIDTH(`LCD_PIXEL_WIDTH), .DEPTH(BUF_DEPTH)) pixelBuffer (
		.clk(clk),
		.rstn(rstSync),
		.fill(toBuf),
		.drain(fromBuf)
	);

	// ============================================================
	// Panel side: one pixel per panel clock rising edge
	logic take;
	logic [11:0] next_panelPixel;
	assign take = clkEdge && running;
	assign fromBuf.ready = take;
	assign underrun = take && !fromBuf.valid;

	always_comb begin
		next_panelPixel = panelPixel;
		if (take && fromBuf.valid) begin
			next_panelPixel = fromBuf.data;
		end
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			panelPixel <= 12'h000;
			pixelStrobe <= 1'b0;
		end else begin
			panelPixel <= next_panelPixel;
			pixelStrobe <= take && fromBuf.valid;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync);

	chk_power_on: assert property ((controllerEnable && panelPowerEnable) |=> panelPowerOn)
		else $error("panel power not raised");
	chk_power_off: assert property (!(controllerEnable && panelPowerEnable) |=> !panelPowerOn)
		else $error("panel power on without both enables");
	chk_base_copy: assert property ((startEv && (controllerEnable || running)) |=>
		(currentAddress == {1'b0, $past(frameBaseAddress[30:0])}) && displayStatus[`LCD_ST_NEXT_BASE])
		else $error("base not copied or next flag missing");
	chk_addr_msb: assert property (!currentAddress[31])
		else $error("current address top bit set");
	chk_stop_frame: assert property ((endEv && running && !controllerEnable) |=>
		!running && displayStatus[`LCD_ST_STOPPED])
		else $error("stop not taken at frame end");
	chk_run_hold: assert property ((running && !endEv) |=> running)
		else $error("stopped before frame end");
	chk_irq_or: assert property (interrupt == |(displayStatus & displayStatusMask))
		else $error("interrupt not OR of masked status");
	chk_flag_sticky: assert property ((displayStatus[`LCD_ST_DMA_DONE] && !statusClear[`LCD_ST_DMA_DONE])
		|=> displayStatus[`LCD_ST_DMA_DONE])
		else $error("status flag lost without clear");
	chk_underrun_set: assert property ((take && !fromBuf.valid) |=> displayStatus[`LCD_ST_UNDERRUN])
		else $error("under-run not flagged");
	chk_color8_split: assert property ((toBuf.valid && !monoSelect && bitsPerPixel == `LCD_BPP_8) |->
		toBuf.data[11:8] == redPalette[{heldByte[7:5], 2'h0} +: 4] &&
		toBuf.data[3:0] == bluePalette[{heldByte[1:0], 2'h0} +: 4])
		else $error("8 bpp colour split wrong");
	chk_order_msb: assert property ((toBuf.valid && !pixelOrderSelect && bitsPerPixel == `LCD_BPP_1) |->
		toBuf.data[11:8] == (heldByte[3'h7 - pixIdx] ? redPalette[7:4] : redPalette[3:0]))
		else $error("first pixel not in MSB");
	chk_mono_high: assert property ((toBuf.valid && monoSelect && bitsPerPixel == `LCD_BPP_4 && curPixel[3]) |->
		toBuf.data[3:0] == greenPalette[{curPixel[2:0], 2'h0} +: 4])
		else $error("mono high value not from high palette");

	cov_base_copy: cover property (startEv && controllerEnable ##1 displayStatus[`LCD_ST_NEXT_BASE]);
	cov_stop: cover property (endEv && running && !controllerEnable);
	cov_underrun: cover property (take && !fromBuf.valid);
	cov_color8: cover property (toBuf.valid && toBuf.ready && bitsPerPixel == `LCD_BPP_8 && !monoSelect);
endmodule : lcd_frame_data_and_status
`default_nettype wire

/* src/lcd_frame_data_defines.svh */
// Constants of the frame-data, palette and status block
`ifndef LCD_FRAME_DATA_DEFINES_SVH
`define LCD_FRAME_DATA_DEFINES_SVH

// ============================================================
// Bits per pixel codes
`define LCD_BPP_1 2'h0
`define LCD_BPP_2 2'h1
`define LCD_BPP_4 2'h2
`define LCD_BPP_8 2'h3

// ============================================================
// Status, mask and interrupt bit positions
`define LCD_ST_UNDERRUN 0
`define LCD_ST_NEXT_BASE 1
`define LCD_ST_DMA_DONE 2
`define LCD_ST_STOPPED 3
`define LCD_ST_WIDTH 4
`define LCD_ST_RESET 4'h0

// ============================================================
// Widths and reset values
`define LCD_ADDR_LOW_BITS 6
`define LCD_ADDR_RESET 32'h00000000
`define LCD_PIXEL_WIDTH 12
`define LCD_BUF_DEPTH 2

`endif

/* src/lcd_frame_pkg.sv */
// Types of the frame-data, palette and status block
package lcd_frame_pkg;
	typedef enum logic [0:0] {
		UNPACK_EMPTY,
		UNPACK_HOLD
	} unpack_state_e;
	typedef logic [11:0] pixel_t;
	typedef logic [3:0] status_t;
endpackage : lcd_frame_pkg

/* src/lcd_pixel_buffer.sv */
// Small pixel FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_buffer #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	input wire logic clk, // Block clock
	input wire logic rstn, // Synchronised active-low reset
	lcd_stream_if.snk fill, // Filling side
	lcd_stream_if.src drain // Draining side
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
	logic [CW-1:0] count, next_count;
	logic push, pop;

	assign fill.ready = (count != FULL);
	assign drain.valid = (count != '0);
	assign drain.data = mem[rdPtr];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_comb begin
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_count = count;
		if (push) begin
			next_wrPtr = (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
		end
		if (pop) begin
			next_rdPtr = (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end

	// Storage has no reset; entries are only read once written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= fill.data;
		end
	end
endmodule : lcd_pixel_buffer
`default_nettype wire

/* src/lcd_stream_if.sv */
// Valid/ready pixel stream between the unpacker, buffer and panel side
`timescale 1ns/1ps
`default_nettype none
interface lcd_stream_if #(parameter int WIDTH = 12);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lcd_stream_if
`default_nettype wire

/* verif/lcd_panel_model.sv */
// Far-side model: frame memory byte source and panel pixel sink
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
	input wire logic clk, // Block clock
	input wire logic fetchReady, // Byte accepted
	output logic fetchValid, // Byte offered
	output logic [7:0] fetchByte, // Frame byte
	output logic panelClk, // Panel pixel clock
	input wire logic [11:0] panelPixel, // Translated pixel
	input wire logic pixelStrobe // Pixel taken
);
	logic [7:0] src[$];
	logic [11:0] got[$];
	logic clkOn = 1'b0;
	logic takeNow = 1'b0;
	initial begin
		fetchValid = 1'b0;
		fetchByte = 8'h5A;
		panelClk = 1'b0;
		#7;
		// Panel clock runs only inside frames
		forever begin
			#160;
			panelClk = clkOn ? ~panelClk : 1'b0;
		end
	end
	// Value just before the rising edge
	always @(negedge clk) begin
		takeNow = fetchValid && fetchReady;
		if (pixelStrobe) begin
			got.push_back(panelPixel);
		end
	end
	always @(posedge clk) begin
		if (takeNow) begin
			void'(src.pop_front());
		end
		#1;
		fetchValid = src.size() != 0;
		// Nothing offered: no stale byte on the bus
		fetchByte = (src.size() != 0) ? src[0] : ~fetchByte;
	end
endmodule : lcd_panel_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking testbench of the frame-data, palette and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic controllerEnable = 1'b0;
	logic panelPowerEnable = 1'b0;
	logic monoSelect = 1'b0;
	logic pixelOrderSelect = 1'b0;
	logic frameStart = 1'b0;
	logic frameEnd = 1'b0;
	logic [1:0] bitsPerPixel = 2'h0;
	logic [31:0] frameBaseAddress = 32'h00000000;
	logic [31:0] redPalette = 32'hFEDCBA98;
	logic [31:0] greenPalette = 32'h0123C567;
	logic [15:0] bluePalette = 16'h5A3C;
	logic [3:0] displayStatusMask = 4'h0;
	logic [3:0] statusClear = 4'h0;
	logic fetchValid, fetchReady, panelClk, pixelStrobe, panelPowerOn, running, interrupt;
	logic [7:0] fetchByte;
	logic [31:0] currentAddress;
	logic [11:0] panelPixel;
	logic [3:0] displayStatus, displayInterruptFlags;
	int n_mismatch = 0;
	int num_checks = 0;

	always #20 clk = ~clk;

	lcd_frame_data_and_status #(.BUF_DEPTH(2)) lcd_frame_data_and_status_inst (.clk, .rstn, .controllerEnable,
		.panelPowerEnable, .monoSelect, .bitsPerPixel, .pixelOrderSelect, .frameBaseAddress, .redPalette,
		.greenPalette, .bluePalette, .displayStatusMask, .statusClear, .fetchValid, .fetchByte, .fetchReady,
		.panelClk, .frameStart, .frameEnd, .currentAddress, .panelPixel, .pixelStrobe, .panelPowerOn, .running,
		.displayStatus, .displayInterruptFlags, .interrupt);
	lcd_panel_model lcd_panel_model_inst (.clk, .fetchReady, .fetchValid, .fetchByte, .panelClk, .panelPixel,
		.pixelStrobe);

	// ============================================================
	// Helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Frame start or end level, long enough for the pin synchronisers
	task automatic pinPulse(input bit isEnd);
		if (isEnd) frameEnd = 1'b1;
		else frameStart = 1'b1;
		tick(6);
		frameStart = 1'b0;
		frameEnd = 1'b0;
		tick(6);
	endtask : pinPulse

	function automatic logic [11:0] expPix(input logic mono, input logic [1:0] bpp, input logic ord,
		input logic [7:0] b, input int k);
		int w;
		int pos;
		logic [7:0] v;
		logic [3:0] g;
		w = 1 << bpp;
		pos = ord ? k * w : 8 - w * (k + 1);
		v = (b >> pos) & ((1 << w) - 1);
		if (mono) begin
			g = v[3] ? greenPalette[4 * v[2:0] +: 4] : redPalette[4 * v[2:0] +: 4];
			return {g, g, g};
		end
		if (bpp == 2'h3) return {redPalette[4 * v[7:5] +: 4], greenPalette[4 * v[4:2] +: 4], bluePalette[4 * v[1:0] +: 4]};
		return {redPalette[4 * v[2:0] +: 4], greenPalette[4 * v[2:0] +: 4], bluePalette[4 * v[1:0] +: 4]};
	endfunction : expPix

	// One frame in a mode: start, two bytes of pixels, underrun, stop
	task automatic runMode(input logic mono, input logic [1:0] bpp, input logic ord, input logic [7:0] b0,
		input logic [7:0] b1);
		int n;
		int t;
		logic [11:0] e;
		n = 8 >> bpp;
		monoSelect = mono;
		bitsPerPixel = bpp;
		pixelOrderSelect = ord;
		displayStatusMask = 4'h2;
		statusClear = 4'hF;
		tick(1);
		statusClear = 4'h0;
		controllerEnable = 1'b1;
		pinPulse(1'b0);
		check(running, 1);
		check(currentAddress, {1'b0, frameBaseAddress[30:0]});
		check(displayInterruptFlags, 4'h2);
		check(interrupt, 1);
		frameBaseAddress = frameBaseAddress + 32'h40;
		statusClear = 4'h2;
		tick(1);
		statusClear = 4'h0;
		tick(1);
		check({interrupt, displayStatus[1]}, 0);
		lcd_panel_model_inst.src.push_back(b0);
		lcd_panel_model_inst.src.push_back(b1);
		lcd_panel_model_inst.clkOn = 1'b1;
		t = 0;
		while (lcd_panel_model_inst.got.size() < 2 * n && t < 2000) begin
			tick(1);
			t++;
		end
		check(t < 2000, 1);
		for (int k = 0; k < 2 * n; k++) begin
			e = expPix(mono, bpp, ord, k < n ? b0 : b1, k % n);
			check(lcd_panel_model_inst.got[k], e);
		end
		tick(40);
		check(displayStatus[0], 1);
		lcd_panel_model_inst.clkOn = 1'b0;
		lcd_panel_model_inst.got.delete();
		controllerEnable = 1'b0;
		tick(2);
		check(running, 1);
		pinPulse(1'b1);
		check({running, displayStatus[3:2]}, 3'h3);
	endtask : runMode

	// ============================================================
	// Closing
	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	initial begin
		#1_000_000;
		n_mismatch++;
		results();
	end

	// ============================================================
	// Main sequence
	initial begin
		tick(3);
		rstn = 1'b1;
		tick(3);
		check({running, panelPowerOn, interrupt, fetchReady, displayStatus}, 0);
		check(currentAddress, 0);
		for (int i = 0; i < 4; i++) begin
			{controllerEnable, panelPowerEnable} = i[1:0];
			tick(2);
			check(panelPowerOn, i == 3);
		end
		panelPowerEnable = 1'b0;
		tick(2);
		// Power-up and power-down order, enable spacing scaled down to fit the run
		controllerEnable = 1'b1;
		tick(50);
		panelPowerEnable = 1'b1;
		tick(2);
		check(panelPowerOn, 1);
		panelPowerEnable = 1'b0;
		tick(2);
		check(panelPowerOn, 0);
		tick(50);
		controllerEnable = 1'b0;
		frameBaseAddress = 32'hFFFFFFC0;
		runMode(1'b0, 2'h3, 1'b0, 8'hB6, 8'h4D);
		runMode(1'b0, 2'h2, 1'b0, 8'h9E, 8'h37);
		runMode(1'b0, 2'h1, 1'b1, 8'h1B, 8'hE4);
		runMode(1'b0, 2'h0, 1'b0, 8'hA5, 8'h3C);
		bluePalette = 16'hC3A5;
		runMode(1'b1, 2'h2, 1'b1, 8'hB3, 8'h7F);
		runMode(1'b1, 2'h1, 1'b0, 8'h2D, 8'hC6);
		runMode(1'b1, 2'h0, 1'b1, 8'h96, 8'h0F);
		pinPulse(1'b0);
		check(running, 0);
		results();
	end
endmodule : testbench
`default_nettype wire
